// ---- verilog/serial_ctl_defines.vh ----
/*
  Constants for the serial port low control register block: register
  offsets, field positions, reset values and bus encodings.
  Assumes inclusion by bare name from the design files under verilog/.
*/
`ifndef SERIAL_CTL_DEFINES_VH
`define SERIAL_CTL_DEFINES_VH

// Register byte addresses (word aligned)
`define ADDR_CONTROL_LOW      4'h0
`define ADDR_STATUS_EVENTS    4'h4
`define ADDR_OWN_ADDRESS      4'h8

// Field positions in the low control register
`define BIT_MODULE_ON         15
`define BIT_UNUSED_14         14
`define BIT_HALT_IN_IDLE      13
`define BIT_CLOCK_RELEASE     12
`define BIT_RESERVED_ENFORCE  11
`define BIT_TEN_BIT_ADDR      10
`define BIT_SLEW_OFF          9
`define BIT_SMBUS_LEVELS      8
`define BIT_GENERAL_CALL      7
`define BIT_STRETCH_ENABLE    6
`define BIT_ACK_VALUE         5
`define BIT_ACK_SEQ_GO        4
`define BIT_RECEIVE_GO        3
`define BIT_STOP_GO           2
`define BIT_RESTART_GO        1
`define BIT_START_GO          0

// Reset value: only the clock release bit comes up set
`define CONTROL_LOW_RESET     16'h1000
// Mask of bits software can store (bit 14 is unimplemented)
`define CONTROL_LOW_WMASK     16'hbfff
// Mask of the five self-clearing request bits
`define REQUEST_MASK          5'h1f

// Own address widths
`define OWN_ADDR_WIDTH        10

// AHB-Lite encodings
`define HTRANS_IDLE           2'b00
`define HTRANS_NONSEQ         2'b10
`define HSIZE_WORD            3'b010

`endif

// ---- verilog/bus_clock_hold.v ----
/*
  Clock hold stage for the slave clock line. Decides when the port pulls
  the bus clock low to stretch it, from the release bit and the stretch
  mode. Assumes the bus clock level input is already synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_clock_hold
(
  input  wire i_clk,          // Core clock
  input  wire i_arst_n,       // Async reset, active low
  input  wire i_active,       // Port on and not halted
  input  wire i_release,      // Stored clock release bit
  input  wire i_stretch_en,   // Stretch mode select
  input  wire i_scl_level,    // Sampled bus clock level
  output reg  o_hold_low      // Pull clock line low
);

  // Hold state update
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_hold_low <= 1'b0;
    else if (!i_active || i_release)
      o_hold_low <= 1'b0;                       // Release clock
    else if (!i_stretch_en)
      o_hold_low <= 1'b1;                       // Force low at once
    else if (!i_scl_level)
      o_hold_low <= 1'b1;                       // Wait for a low phase
    // Otherwise keep the current state until the line goes low
  end

endmodule // bus_clock_hold

`default_nettype wire

// ---- verilog/serial_port_control_low.v ----
/*
  Low control register of a two-wire serial port, reached over AHB-Lite,
  with pin ownership, idle halt, clock release and stretch, reserved
  address policy and self-clearing bus request bits.
  Assumes the shift and sequencing logic sits outside and reports its
  events as one-cycle pulses synchronous to the core clock.
*/
// Behaviour
// - Module-on bit gives the port the pins
// - Halt-in-idle stops the port in idle
// - Clock release forced high on reset, off
// - Without stretch, release bit drives clock directly
// - With stretch, hold starts at clock low
// - Release cleared at slave transmit start, receive end
// - Without stretch, clear only at transmit start
// - Enforced: reserved addresses get not-acknowledge
// - Not enforced: matching reserved address acknowledged
// - Ten-bit select picks own address width
// - Request bits reset low, hardware clears them
// - Unimplemented bit reads zero, ignores writes
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctl_defines.vh"

module serial_port_control_low
(
  input  wire        I_CORE_CLK,        // Core clock, 200 MHz
  input  wire        I_ARST_N,          // Async reset, active low
  // AHB-Lite slave
  input  wire        I_HSEL,            // Slave select
  input  wire [31:0] I_HADDR,           // Address
  input  wire [1:0]  I_HTRANS,          // Transfer type
  input  wire        I_HWRITE,          // Write strobe
  input  wire [2:0]  I_HSIZE,           // Transfer size
  input  wire [31:0] I_HWDATA,          // Write data
  input  wire        I_HREADY,          // Bus ready
  output reg  [31:0] O_HRDATA,          // Read data
  output reg         O_HREADYOUT,       // Slave ready
  output reg         O_HRESP,           // Always OKAY
  // Device and bus state
  input  wire        i_idle_mode,       // Device in idle mode
  input  wire        i_scl_in,          // Sampled bus clock level
  input  wire        i_sda_in,          // Sampled bus data level
  // Events from the sequencing logic
  input  wire        i_slave_tx_start,  // Slave transmission begins
  input  wire        i_slave_rx_end,    // Slave reception ends
  input  wire        i_addr_valid,      // Received address byte valid
  input  wire [7:0]  i_addr_byte,       // Received address byte
  input  wire [4:0]  i_request_done,    // Request complete, per bit
  // Pin control
  output reg         O_PIN_OWN,         // Port owns data and clock pins
  output reg         O_PORT_RUN,        // Port logic running
  output reg         O_SCL_OUT,         // Clock pin output value
  output reg         O_SCL_OE,          // Clock pin drive enable
  output reg         O_ADDR_ACK,        // Acknowledge received address
  output reg         O_ADDR_NACK,       // Refuse received address
  // Plain control bits to the sequencer
  output reg  [15:0] O_CONTROL          // Current control register
);

  // Address phase capture
  reg        wr_pend_ff;               // Write data phase pending
  reg        rd_pend_ff;               // Read data phase pending
  reg  [3:0] addr_ff;                  // Latched word address
  reg [15:0] ctl_ff;                   // Control register
  reg [15:0] nxt_ctl;                  // Next control value
  reg  [9:0] own_addr_ff;              // Own slave address
  reg  [1:0] events_ff;                // Sticky seen-event bits
  reg  [1:0] nxt_events;               // Next event bits
  reg        scl_d1_ff;                // Clock line sample
  wire       hold_low;                 // Clock stretch request
  wire       active;                   // Port on and not halted
  wire       addr_phase;               // Valid address phase
  wire       reserved_hit;             // Address in reserved space
  wire       own_match;                // Address matches our own
  wire [6:0] addr7;                    // Seven-bit part of address

  assign addr_phase = I_HSEL && I_HREADY && (I_HTRANS == `HTRANS_NONSEQ);

  // Port runs only when on and not halted by idle
  assign active = ctl_ff[`BIT_MODULE_ON] &&
                  !(ctl_ff[`BIT_HALT_IN_IDLE] && i_idle_mode);

  // Reserved space: 0000xxx and 1111xxx
  assign addr7        = i_addr_byte[7:1];
  assign reserved_hit = (addr7[6:3] == 4'h0) || (addr7[6:3] == 4'hf);

  // Ten-bit first byte is 11110 plus address bits 9:8
  assign own_match = ctl_ff[`BIT_TEN_BIT_ADDR] ?
                     (i_addr_byte[7:1] == {5'h1e, own_addr_ff[9:8]}) :
                     (addr7 == own_addr_ff[6:0]);

  // Bus handshake; every access completes with no wait state
  always @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      wr_pend_ff  <= 1'b0;
      rd_pend_ff  <= 1'b0;
      addr_ff     <= 4'h0;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end
    else
    begin
      wr_pend_ff  <= addr_phase && I_HWRITE;
      rd_pend_ff  <= addr_phase && !I_HWRITE;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      if (addr_phase)
        addr_ff <= I_HADDR[3:0];
    end
  end

  // Control register next value
  always @*
  begin
    nxt_ctl = ctl_ff;
    // Software write; bit 14 never stored
    if (wr_pend_ff && (addr_ff == `ADDR_CONTROL_LOW))
      nxt_ctl = I_HWDATA[15:0] & `CONTROL_LOW_WMASK;
    // Hardware clears requests as actions complete
    nxt_ctl[4:0] = nxt_ctl[4:0] & ~(i_request_done & `REQUEST_MASK);
    // Automatic release clearing by slave events
    if (i_slave_tx_start)
      nxt_ctl[`BIT_CLOCK_RELEASE] = 1'b0;
    else if (i_slave_rx_end && ctl_ff[`BIT_STRETCH_ENABLE])
      nxt_ctl[`BIT_CLOCK_RELEASE] = 1'b0;
    // Port off forces release high, overriding everything
    if (!nxt_ctl[`BIT_MODULE_ON])
      nxt_ctl[`BIT_CLOCK_RELEASE] = 1'b1;
    nxt_ctl[`BIT_UNUSED_14] = 1'b0;
  end

  // Control register
  always @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      ctl_ff <= `CONTROL_LOW_RESET;
    else
      ctl_ff <= nxt_ctl;
  end

  // Own address register
  always @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      own_addr_ff <= 10'h000;
    else if (wr_pend_ff && (addr_ff == `ADDR_OWN_ADDRESS))
      own_addr_ff <= I_HWDATA[9:0];
  end

  // Sticky event record: set wins over a write-one clear
  always @*
  begin
    nxt_events = events_ff;
    if (wr_pend_ff && (addr_ff == `ADDR_STATUS_EVENTS))
      nxt_events = events_ff & ~I_HWDATA[1:0];
    if (i_slave_tx_start)
      nxt_events[0] = 1'b1;
    if (i_slave_rx_end)
      nxt_events[1] = 1'b1;
  end

  always @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      events_ff <= 2'b00;
    else
      events_ff <= nxt_events;
  end

  // Read data, decoded from I_HADDR in the address phase
  always @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_HRDATA <= 32'h0000_0000;
    else if (addr_phase && !I_HWRITE)
    begin
      if (I_HADDR[3:0] == `ADDR_CONTROL_LOW)
        O_HRDATA <= {16'h0000, nxt_ctl};
      else if (I_HADDR[3:0] == `ADDR_STATUS_EVENTS)
        O_HRDATA <= {27'h0, i_sda_in, scl_d1_ff, hold_low, nxt_events};
      else if (I_HADDR[3:0] == `ADDR_OWN_ADDRESS)
        O_HRDATA <= {22'h0, own_addr_ff};
      else
        O_HRDATA <= 32'h0000_0000;  // Unmapped reads zero
    end
  end

  // Clock level sample for status
  always @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      scl_d1_ff <= 1'b1;
    else
      scl_d1_ff <= i_scl_in;
  end

  // Clock stretch stage
  bus_clock_hold u_hold
  (
    .i_clk        (I_CORE_CLK),
    .i_arst_n     (I_ARST_N),
    .i_active     (active),
    .i_release    (ctl_ff[`BIT_CLOCK_RELEASE]),
    .i_stretch_en (ctl_ff[`BIT_STRETCH_ENABLE]),
    .i_scl_level  (i_scl_in),
    .o_hold_low   (hold_low)
  );

  // Pin and address decision outputs, all registered
  always @(posedge I_CORE_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_PIN_OWN   <= 1'b0;
      O_PORT_RUN  <= 1'b0;
      O_SCL_OUT   <= 1'b0;
      O_SCL_OE    <= 1'b0;
      O_ADDR_ACK  <= 1'b0;
      O_ADDR_NACK <= 1'b0;
      O_CONTROL   <= `CONTROL_LOW_RESET;
    end
    else
    begin
      O_PIN_OWN   <= ctl_ff[`BIT_MODULE_ON];
      O_PORT_RUN  <= active;
      O_SCL_OUT   <= 1'b0;                                     // Open drain: low only
      O_SCL_OE    <= hold_low && ctl_ff[`BIT_MODULE_ON];
      O_CONTROL   <= ctl_ff;
      // Reserved policy; a reserved address only answers if it matches
      if (i_addr_valid && active)
      begin
        if (reserved_hit && ctl_ff[`BIT_RESERVED_ENFORCE])
        begin
          O_ADDR_ACK  <= 1'b0;
          O_ADDR_NACK <= 1'b1;
        end
        else
        begin
          O_ADDR_ACK  <= own_match;
          O_ADDR_NACK <= !own_match;
        end
      end
      else
      begin
        O_ADDR_ACK  <= 1'b0;
        O_ADDR_NACK <= 1'b0;
      end
    end
  end

endmodule // serial_port_control_low

`default_nettype wire

// ---- dv/serial_ctl_properties.sv ----
/* Checker for the serial port low control register.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module serial_ctl_props
(
  input wire logic        I_CORE_CLK,
  input wire logic        I_ARST_N,
  input wire logic        i_idle_mode,
  input wire logic        i_slave_tx_start,
  input wire logic        i_slave_rx_end,
  input wire logic        i_addr_valid,
  input wire logic [7:0]  i_addr_byte,
  input wire logic [4:0]  i_request_done,
  input wire logic        O_PIN_OWN,
  input wire logic        O_PORT_RUN,
  input wire logic        O_SCL_OE,
  input wire logic        O_ADDR_ACK,
  input wire logic        O_ADDR_NACK,
  input wire logic [15:0] O_CONTROL
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);
  // Field aliases
  wire on  = O_CONTROL[15];
  wire rel = O_CONTROL[12];
  wire str = O_CONTROL[6];
  // Seven-bit address 0000xxx or 1111xxx
  wire rsv = (i_addr_byte[7:4] == 4'h0) || (i_addr_byte[7:4] == 4'hf);
  property p_pin; O_PIN_OWN == on; endproperty
  a_pin: assert property (p_pin) else $error("pin ownership wrong");
  property p_run; O_PORT_RUN == (on && !(O_CONTROL[13] && $past(i_idle_mode))); endproperty
  a_run: assert property (p_run) else $error("run state wrong");
  // One cycle of lag allowed after switching off
  property p_off; !on && !$past(on) |-> rel; endproperty
  a_off: assert property (p_off) else $error("release not forced");
  property p_b14; O_CONTROL[14] == 1'b0; endproperty
  a_b14: assert property (p_b14) else $error("bit 14 set");
  property p_tx; i_slave_tx_start && on |-> ##2 !rel; endproperty
  a_tx: assert property (p_tx) else $error("release kept at tx start");
  property p_rxs; i_slave_rx_end && on && str |-> ##2 !rel; endproperty
  a_rxs: assert property (p_rxs) else $error("release kept at rx end");
  property p_rxk; i_slave_rx_end && !i_slave_tx_start && on && !str && rel |-> ##2 rel;
  endproperty
  a_rxk: assert property (p_rxk) else $error("release cleared at rx end");
  property p_nack; i_addr_valid && O_CONTROL[11] && rsv |=> O_ADDR_NACK && !O_ADDR_ACK;
  endproperty
  a_nack: assert property (p_nack) else $error("reserved address answered");
  property p_ans;
    O_ADDR_ACK || O_ADDR_NACK |-> $past(i_addr_valid) && !(O_ADDR_ACK && O_ADDR_NACK);
  endproperty
  a_ans: assert property (p_ans) else $error("answer without address");
  property p_req; i_request_done[0] |-> ##2 !O_CONTROL[0]; endproperty
  a_req: assert property (p_req) else $error("start request not cleared");
  property p_drop; $past(rel) || !$past(O_PORT_RUN) |-> !O_SCL_OE; endproperty
  a_drop: assert property (p_drop) else $error("clock held while released");
  property p_hold; $past(O_PORT_RUN && !rel && !str) |-> O_SCL_OE; endproperty
  a_hold: assert property (p_hold) else $error("clock not held");
  c_nack: cover property (O_ADDR_NACK);
  c_ack: cover property (O_ADDR_ACK);
  c_hold: cover property (O_SCL_OE && str);
endmodule // serial_ctl_props
bind serial_port_control_low serial_ctl_props u_props (.I_CORE_CLK(I_CORE_CLK),
  .I_ARST_N(I_ARST_N), .i_idle_mode(i_idle_mode), .i_slave_tx_start(i_slave_tx_start),
  .i_slave_rx_end(i_slave_rx_end), .i_addr_valid(i_addr_valid), .i_addr_byte(i_addr_byte),
  .i_request_done(i_request_done), .O_PIN_OWN(O_PIN_OWN), .O_PORT_RUN(O_PORT_RUN),
  .O_SCL_OE(O_SCL_OE), .O_ADDR_ACK(O_ADDR_ACK), .O_ADDR_NACK(O_ADDR_NACK),
  .O_CONTROL(O_CONTROL));
`default_nettype wire

// ---- dv/bus_party_model.sv ----
/* Other party on the two-wire bus: clocks frames, raises slave events
   and address bytes. Assumes the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module bus_party_model
(
  input  wire logic       i_clk,
  input  wire logic       i_scl_hold,   // Port pulls clock low
  output wire logic       o_scl,        // Wired clock level
  output var  logic       o_sda,        // Data, pulled up
  output var  logic       o_tx_start,
  output var  logic       o_rx_end,
  output var  logic       o_addr_valid,
  output var  logic [7:0] o_addr_byte
);
  // Clock rests high between frames: pull-up, nobody drives
  logic scl_drv = 1'b1;
  assign o_scl = scl_drv & ~i_scl_hold;
  initial
  begin
    o_sda = 1'b1;
    o_tx_start = 1'b0;
    o_rx_end = 1'b0;
    o_addr_valid = 1'b0;
    o_addr_byte = 8'h00;
  end
  // One-cycle event: 0 tx start, 1 rx end
  task ev(input int k);
    @(posedge i_clk);
    if (k == 0) o_tx_start <= 1'b1;
    else o_rx_end <= 1'b1;
    @(posedge i_clk);
    o_tx_start <= 1'b0;
    o_rx_end <= 1'b0;
  endtask
  task addr(input logic [7:0] b);
    @(posedge i_clk);
    o_addr_valid <= 1'b1;
    o_addr_byte <= b;
    @(posedge i_clk);
    o_addr_valid <= 1'b0;
    o_addr_byte <= ~b; // Stale byte is garbage
  endtask
  // n full clock periods, two core cycles per phase
  task frame(input int n);
    repeat (2 * n)
    begin
      repeat (2) @(posedge i_clk);
      scl_drv <= ~scl_drv;
    end
  endtask
endmodule // bus_party_model
`default_nettype wire

// ---- dv/tb_serial_port_control_low.sv ----
/* Self-checking bench for the low control register block.
   Assumes the bound checker and the bus party model. */
`timescale 1ns/1ps
`default_nettype none
`include "serial_ctl_defines.vh"
module tb_serial_port_control_low;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic sel_en = 1'b1;
  logic [2:0] hsize = 3'b000;
  logic idle = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = `HTRANS_IDLE;
  logic [4:0] rdone = 5'h00;
  logic [15:0] ctl;
  logic hro, hresp, pown, run, sclo, oe, ack, nack, scl, sda, txs, rxe, av;
  logic [7:0] ab;
  int miscompares = 0;
  int num_checks = 0;
  localparam logic [31:0] CTL = `ADDR_CONTROL_LOW;
  always #2.5 clk = ~clk;
  serial_port_control_low dut (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hro), .O_HRDATA(hrdata), .O_HREADYOUT(hro),
    .O_HRESP(hresp), .i_idle_mode(idle), .i_scl_in(scl), .i_sda_in(sda),
    .i_slave_tx_start(txs), .i_slave_rx_end(rxe), .i_addr_valid(av), .i_addr_byte(ab),
    .i_request_done(rdone), .O_PIN_OWN(pown), .O_PORT_RUN(run), .O_SCL_OUT(sclo),
    .O_SCL_OE(oe), .O_ADDR_ACK(ack), .O_ADDR_NACK(nack), .O_CONTROL(ctl));
  bus_party_model pm (.i_clk(clk), .i_scl_hold(oe), .o_scl(scl), .o_sda(sda),
    .o_tx_start(txs), .o_rx_end(rxe), .o_addr_valid(av), .o_addr_byte(ab));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One single AHB transfer; waits on ready in both phases
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    htrans <= `HTRANS_NONSEQ;
    hsel <= sel_en;
    hsize <= `HSIZE_WORD;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
    htrans <= `HTRANS_IDLE;
    hwdata <= d;
    @(posedge clk);
    while (hro !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask
  // Settle a few cycles, then compare one output
  task look(input string what, input logic exp, input logic got_now);
    repeat (4) @(posedge clk);
    #1 chk(what, {31'h0, exp}, {31'h0, oe});
  endtask
  task idle_run(input logic exp);
    @(posedge clk);
    idle <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("run", {31'h0, exp}, {31'h0, run});
    @(posedge clk);
    idle <= 1'b0;
  endtask
  task ans(input logic [7:0] b, input logic [1:0] exp);
    pm.addr(b);
    #1 chk("ack nack", {30'h0, exp}, {30'h0, ack, nack});
  endtask
  task t_regs;
    rd("ctl reset", CTL, 32'h0000_1000);
    chk("okay", 32'h0, {30'h0, sclo, hresp});
    // A transfer with the slave unselected must not land
    sel_en = 1'b0;
    wr(CTL, 32'hffff_ffff);
    sel_en = 1'b1;
    rd("ctl unselected", CTL, 32'h0000_1000);
    wr(CTL, 32'hffff_ffff);
    rd("ctl all", CTL, 32'h0000_bfff);
    chk("pin own", 32'h1, {31'h0, pown});
    @(posedge clk);
    rdone <= 5'h1f;
    @(posedge clk);
    rdone <= 5'h00;
    rd("ctl done", CTL, 32'h0000_bfe0);
    wr(CTL, 32'h0);
    rd("ctl off", CTL, 32'h0000_1000);
    rd("unmapped", 32'hc, 32'h0);
    chk("pin off", 32'h0, {31'h0, pown});
  endtask
  task t_idle_stretch;
    wr(CTL, 32'h0000_b000);
    idle_run(1'b0);
    wr(CTL, 32'h0000_9000);
    idle_run(1'b1);
    wr(CTL, 32'h0000_8000);
    look("hold", 1'b1, oe);
    wr(CTL, 32'h0000_9000);
    look("free", 1'b0, oe);
    wr(CTL, 32'h0000_8040);
    look("wait low", 1'b0, oe);
    pm.frame(2);
    look("hold low", 1'b1, oe);
  endtask
  task t_auto;
    wr(CTL, 32'h0000_9000);
    pm.ev(1);
    rd("rx keep", CTL, 32'h0000_9000);
    pm.ev(0);
    rd("tx clear", CTL, 32'h0000_8000);
    wr(CTL, 32'h0000_9040);
    pm.ev(1);
    rd("rx clear", CTL, 32'h0000_8040);
  endtask
  task t_addr;
    wr(`ADDR_OWN_ADDRESS, 32'h03);
    wr(CTL, 32'h0000_9800);
    ans(8'h06, 2'b01);
    ans(8'hf0, 2'b01);
    wr(CTL, 32'h0000_9000);
    ans(8'h06, 2'b10);
    wr(`ADDR_OWN_ADDRESS, 32'h2a5);
    rd("own addr", `ADDR_OWN_ADDRESS, 32'h0000_02a5);
    wr(CTL, 32'h0000_9400);
    ans(8'hf4, 2'b10);
    wr(CTL, 32'h0000_9000);
    ans(8'h4a, 2'b10);
    pm.addr(8'hf4);
    #1 chk("ack 7-bit", 32'h0, {31'h0, ack});
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Whole run is under two hundred cycles
  initial
  begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_idle_stretch;
    t_auto;
    t_addr;
    tally_and_finish;
  end
endmodule // tb_serial_port_control_low
`default_nettype wire
